// ---- i2c_fifo_flags.sv ----
// Purpose: FIFO levels, raw flags, thresholds and read-to-clear registers of an I2C controller.
// Assumes: Event strobes come from logic on ref_clk; one register access per cycle.
// Notes: Register reads answer one cycle after the request.
`include "i2c_flags_map.svh"
`timescale 1ns/1ps
`default_nettype none
module i2c_fifo_flags #(
  parameter int DEPTH = `FIFO_DEPTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register access
  input wire i2c_flags_pkg::reg_req_t reg_req,
  output logic [15:0] reg_rdata,
  // Controller state
  input wire logic enable_bit,
  input wire logic bus_active,
  input wire logic abort_event,
  input wire logic abort_clear_read,
  // FIFO movements
  input wire i2c_flags_pkg::fifo_event_t fifo_ev,
  output logic tx_push_taken,
  output logic rx_byte_ack,
  output logic rx_byte_stored,
  output logic rx_pop_valid,
  // Status towards the rest of the controller
  output logic internal_enable,
  output logic tx_flushed,
  output logic clear_all_pulse,
  output logic [5:0] tx_level,
  output logic [5:0] rx_level,
  output i2c_flags_pkg::raw_flags_t raw_flags
);
  import i2c_flags_pkg::*;

  localparam logic [5:0] DEPTH_L = 6'(DEPTH);
  localparam logic [4:0] MAX_CODE = 5'(DEPTH - 1);

  logic [5:0] tx_level_q;
  logic [5:0] rx_level_q;
  logic [4:0] rx_thr_q;
  logic [4:0] tx_thr_q;
  logic ien_q;
  logic flush_q;
  logic tx_over_q;
  logic rx_over_q;
  logic empty_rd_q;
  logic [15:0] rdata_q;
  logic rd;
  logic wr;
  logic rd_clr_all;
  logic rd_clr_empty;
  logic tx_full;
  logic rx_full;
  logic rx_empty;
  logic tx_push_ok;
  logic tx_pop_ok;
  logic rx_push_ok;
  logic rx_pop_ok;
  logic [5:0] tx_thr_entries;
  logic [5:0] rx_thr_entries;
  logic tx_level_flag;
  logic rx_level_flag;
  logic [15:0] rd_val;

  // Access decode
  assign rd = reg_req.sel & ~reg_req.write;
  assign wr = reg_req.sel & reg_req.write;
  assign rd_clr_all = rd & (reg_req.addr == `CLEAR_ALL_FLAGS_ADDR);
  assign rd_clr_empty = rd & (reg_req.addr == `CLEAR_EMPTY_READ_ADDR);

  // Internal enable stays high while disabled only until the bus goes idle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ien_q <= 1'b0;
    end else begin
      ien_q <= enable_bit | (ien_q & bus_active);
    end
  end

  // Transmit flush held from abort until an abort-clear read or a clear-all read
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flush_q <= 1'b0;
    end else if (abort_event) begin
      flush_q <= 1'b1;
    end else if (abort_clear_read | rd_clr_all) begin
      flush_q <= 1'b0;
    end
  end

  // FIFO occupancy qualifiers
  assign tx_full = (tx_level_q == DEPTH_L);
  assign rx_full = (rx_level_q == DEPTH_L);
  assign rx_empty = (rx_level_q == 6'h00);
  assign tx_push_ok = fifo_ev.tx_push & ~tx_full & enable_bit & ~flush_q;
  assign tx_pop_ok = fifo_ev.tx_pop & (tx_level_q != 6'h00);
  assign rx_push_ok = fifo_ev.rx_push & ~rx_full & enable_bit;
  assign rx_pop_ok = fifo_ev.rx_pop & ~rx_empty;

  // Transmit level count, emptied while disabled or flushed
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_level_q <= 6'h00;
    end else if (~enable_bit | flush_q | abort_event) begin
      tx_level_q <= 6'h00;
    end else begin
      tx_level_q <= tx_level_q + 6'(tx_push_ok) - 6'(tx_pop_ok);
    end
  end

  // Receive level count, held in reset while enable bit is low
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_level_q <= 6'h00;
    end else if (~enable_bit) begin
      rx_level_q <= 6'h00;
    end else begin
      rx_level_q <= rx_level_q + 6'(rx_push_ok) - 6'(rx_pop_ok);
    end
  end

  // Threshold registers, clamped to the buffer depth minus one
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_thr_q <= `THRESHOLD_RESET;
      tx_thr_q <= `THRESHOLD_RESET;
    end else if (wr && reg_req.addr == `RECEIVE_THRESHOLD_ADDR) begin
      rx_thr_q <= (reg_req.wdata > 16'(MAX_CODE)) ? MAX_CODE : reg_req.wdata[4:0];
    end else if (wr && reg_req.addr == `TRANSMIT_THRESHOLD_ADDR) begin
      tx_thr_q <= (reg_req.wdata > 16'(MAX_CODE)) ? MAX_CODE : reg_req.wdata[4:0];
    end
  end

  // Threshold codes to entry counts
  assign rx_thr_entries = {1'b0, rx_thr_q} + 6'h01;
  assign tx_thr_entries = (tx_thr_q == 5'h1F) ? 6'h20 : {1'b0, tx_thr_q};

  // Level flags are hardware cleared and never touched by clearing reads
  assign rx_level_flag = enable_bit & (rx_level_q >= rx_thr_entries);
  assign tx_level_flag = ien_q & (tx_level_q <= tx_thr_entries);

  // Transmit overrun, set wins over clear-all read
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_over_q <= `FLAG_RESET;
    end else if (~ien_q) begin
      tx_over_q <= 1'b0;
    end else if (fifo_ev.tx_push & tx_full) begin
      tx_over_q <= 1'b1;
    end else if (rd_clr_all) begin
      tx_over_q <= 1'b0;
    end
  end

  // Receive overrun, byte discarded but still acknowledged
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_over_q <= `FLAG_RESET;
    end else if (~ien_q) begin
      rx_over_q <= 1'b0;
    end else if (fifo_ev.rx_push & rx_full) begin
      rx_over_q <= 1'b1;
    end else if (rd_clr_all) begin
      rx_over_q <= 1'b0;
    end
  end

  // Empty read, cleared by either clearing read
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      empty_rd_q <= `FLAG_RESET;
    end else if (~ien_q) begin
      empty_rd_q <= 1'b0;
    end else if (fifo_ev.rx_pop & rx_empty) begin
      empty_rd_q <= 1'b1;
    end else if (rd_clr_all | rd_clr_empty) begin
      empty_rd_q <= 1'b0;
    end
  end

  // Read data mux; reserved bits and clear registers give zero
  always_comb begin
    rd_val = 16'h0000;
    unique case (reg_req.addr)
      `RAW_FLAG_STATUS_ADDR: begin
        rd_val[`TX_LEVEL_BIT] = tx_level_flag;
        rd_val[`TX_OVERRUN_BIT] = tx_over_q;
        rd_val[`RX_LEVEL_BIT] = rx_level_flag;
        rd_val[`RX_OVERRUN_BIT] = rx_over_q;
        rd_val[`EMPTY_READ_BIT] = empty_rd_q;
      end
      `RECEIVE_THRESHOLD_ADDR: rd_val[4:0] = rx_thr_q;
      `TRANSMIT_THRESHOLD_ADDR: rd_val[4:0] = tx_thr_q;
      default: rd_val = 16'h0000;
    endcase
  end

  // Registered read data
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 16'h0000;
    end else if (rd) begin
      rdata_q <= rd_val;
    end
  end

  // Outputs
  assign reg_rdata = rdata_q;
  assign tx_push_taken = tx_push_ok;
  assign rx_byte_ack = fifo_ev.rx_push;
  assign rx_byte_stored = rx_push_ok;
  assign rx_pop_valid = rx_pop_ok;
  assign internal_enable = ien_q;
  assign tx_flushed = flush_q;
  assign clear_all_pulse = rd_clr_all;
  assign tx_level = tx_level_q;
  assign rx_level = rx_level_q;
  assign raw_flags = '{tx_level: tx_level_flag, tx_overrun: tx_over_q, rx_level: rx_level_flag,
                       rx_overrun: rx_over_q, empty_read: empty_rd_q};

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence full_push_s;
    ien_q && fifo_ev.tx_push && tx_full;
  endsequence

  tx_overrun_set_a: assert property (full_push_s |=> tx_over_q)
    else $error("transmit overrun not set on full push");
  disable_clear_a: assert property (!ien_q |=> !tx_over_q && !rx_over_q && !empty_rd_q)
    else $error("error flags survive internal disable");
  hold_busy_a: assert property (!enable_bit && bus_active && ien_q && !rd_clr_all |=> $stable(rx_over_q))
    else $error("receive overrun changed while draining");
  rx_level_flag_a: assert property (rx_level_flag == (enable_bit && rx_level_q > {1'b0, rx_thr_q}))
    else $error("receive level flag wrong");
  rx_flush_a: assert property (!enable_bit |=> rx_level_q == 6'h00 && !raw_flags.rx_level)
    else $error("receive FIFO not flushed");
  rx_overrun_a: assert property (fifo_ev.rx_push && rx_full && ien_q |-> rx_byte_ack && !rx_byte_stored ##1 rx_over_q)
    else $error("receive overrun handling wrong");
  empty_read_a: assert property (ien_q && fifo_ev.rx_pop && rx_empty |=> empty_rd_q)
    else $error("empty read not flagged");
  thr_clamp_a: assert property (wr && reg_req.addr == `RECEIVE_THRESHOLD_ADDR && reg_req.wdata > 16'(MAX_CODE)
                                |=> rx_thr_q == MAX_CODE)
    else $error("receive threshold not clamped");
  tx_level_flag_a: assert property (ien_q && tx_level_q <= tx_thr_entries |-> raw_flags.tx_level)
    else $error("transmit level flag missing");
  clear_all_a: assert property (rd_clr_all && !fifo_ev.tx_push && !fifo_ev.rx_push && !fifo_ev.rx_pop
                                |=> !tx_over_q && !rx_over_q && !empty_rd_q)
    else $error("clear-all read left a flag set");
  clear_empty_a: assert property (rd_clr_empty && !fifo_ev.rx_pop |=> !empty_rd_q)
    else $error("empty read not cleared");
  abort_flush_a: assert property (abort_event |=> flush_q && tx_level_q == 6'h00 ##1 !tx_push_taken)
    else $error("transmit FIFO not flushed after abort");
endmodule : i2c_fifo_flags
`default_nettype wire

// ---- i2c_flags_map.svh ----
// Purpose: Register map, field positions and reset values of the FIFO flag block.
// Assumes: 16-bit register data, full 32-bit byte addresses.
// Notes: Definitions only.
`ifndef I2C_FLAGS_MAP_SVH
`define I2C_FLAGS_MAP_SVH

// Register byte addresses
`define RAW_FLAG_STATUS_ADDR 32'h5000_1334
`define RECEIVE_THRESHOLD_ADDR 32'h5000_1338
`define TRANSMIT_THRESHOLD_ADDR 32'h5000_133C
`define CLEAR_ALL_FLAGS_ADDR 32'h5000_1340
`define CLEAR_EMPTY_READ_ADDR 32'h5000_1344

// Raw status bit positions
`define EMPTY_READ_BIT 0
`define RX_OVERRUN_BIT 1
`define RX_LEVEL_BIT 2
`define TX_OVERRUN_BIT 3
`define TX_LEVEL_BIT 4

// Threshold field width and reset values
`define THRESHOLD_WIDTH 5
`define THRESHOLD_RESET 5'h00
`define FLAG_RESET 1'h0

// FIFO depth in entries
`define FIFO_DEPTH 32

`endif

// ---- i2c_flags_pkg.sv ----
// Purpose: Types shared by the FIFO flag block.
// Assumes: Register data is 16 bits wide.
// Notes: Constants live in i2c_flags_map.svh.
`default_nettype none
package i2c_flags_pkg;
  // Processor register access
  typedef struct packed {
    logic sel;
    logic write;
    logic [31:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  // FIFO movement strobes, one cycle each
  typedef struct packed {
    logic tx_push;
    logic tx_pop;
    logic rx_push;
    logic rx_pop;
  } fifo_event_t;

  // Raw flags in status bit order 4..0
  typedef struct packed {
    logic tx_level;
    logic tx_overrun;
    logic rx_level;
    logic rx_overrun;
    logic empty_read;
  } raw_flags_t;
endpackage : i2c_flags_pkg
`default_nettype wire

// ---- remote_bus_model.sv ----
// Purpose: Remote I2C devices seen as receive and transmit FIFO strobes.
// Assumes: Bench requests change just after rising edges.
// Notes: Slow mode inserts an idle cycle between strobes.
`timescale 1ns/1ps
`default_nettype none
module remote_bus_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Requests from the bench
  input wire logic send_rx,
  input wire logic take_tx,
  input wire logic slow,
  input wire logic busy,
  // Bus side activity
  output logic rx_push,
  output logic tx_pop,
  output logic bus_active
);
  logic gap_q;
  // Idle cycle toggles while slow
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) gap_q <= 1'b0;
    else gap_q <= slow & ~gap_q;
  end
  // Strobes only outside idle cycles
  assign rx_push = send_rx & ~gap_q;
  assign tx_pop = take_tx & ~gap_q;
  // Bus stays busy during any transfer
  assign bus_active = busy | send_rx | take_tx;
endmodule : remote_bus_model
`default_nettype wire

// ---- testbench.sv ----
// Purpose: Self-checking bench for the FIFO flag block.
// Assumes: Register reads answer the cycle after the request.
// Notes: Far side traffic comes from remote_bus_model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import i2c_flags_pkg::*;
  logic ref_clk, rst, enable_bit, abort_event, abort_clear_read, tx_push_b, rx_pop_b;
  logic send_rx, take_tx, slow, busy, rx_push_m, tx_pop_m, bus_active;
  logic tx_push_taken, rx_byte_ack, rx_byte_stored, rx_pop_valid, internal_enable, tx_flushed;
  logic clear_all_pulse;
  logic [5:0] tx_level, rx_level;
  logic [15:0] reg_rdata;
  reg_req_t reg_req;
  fifo_event_t fifo_ev;
  raw_flags_t raw_flags;
  int miscompares = 0;
  int num_checks = 0;
  int push_cnt = 0;
  int store_cnt = 0;
  int pop_cnt = 0;
  int clr_cnt = 0;
  // Status, receive threshold, transmit threshold, clear-all, clear empty-read
  localparam logic [31:0] ad [5] = '{32'h5000_1334, 32'h5000_1338, 32'h5000_133C, 32'h5000_1340, 32'h5000_1344};
  localparam logic [15:0] wv [4] = '{16'h0005, 16'h001F, 16'h0020, 16'hFFFF};
  localparam logic [15:0] ev [4] = '{16'h0005, 16'h001F, 16'h001F, 16'h001F};
  assign fifo_ev = '{tx_push: tx_push_b, tx_pop: tx_pop_m, rx_push: rx_push_m, rx_pop: rx_pop_b};
  i2c_fifo_flags #(.DEPTH(32)) i2c_fifo_flags_inst (.ref_clk, .rst, .reg_req, .reg_rdata,
    .enable_bit, .bus_active, .abort_event, .abort_clear_read, .fifo_ev, .tx_push_taken,
    .rx_byte_ack, .rx_byte_stored, .rx_pop_valid, .internal_enable, .tx_flushed,
    .clear_all_pulse, .tx_level, .rx_level, .raw_flags);
  remote_bus_model remote_bus_model_inst (.ref_clk, .rst, .send_rx, .take_tx, .slow, .busy,
    .rx_push(rx_push_m), .tx_pop(tx_pop_m), .bus_active);
  // 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Count the one-cycle strobes the block answers with
  always @(negedge ref_clk) begin
    if (tx_push_taken === 1'b1) push_cnt++;
    if (rx_byte_stored === 1'b1) store_cnt++;
    if (rx_pop_valid === 1'b1) pop_cnt++;
    if (clear_all_pulse === 1'b1) clr_cnt++;
  end
  // Compare and count
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One register access, ends an edge after the answer
  task automatic acc(input logic w, input logic [31:0] a, input logic [15:0] d);
    reg_req <= '{sel: 1'b1, write: w, addr: a, wdata: d};
    @(posedge ref_clk);
    reg_req.sel <= 1'b0;
    @(posedge ref_clk);
  endtask : acc
  task automatic rd(input logic [31:0] a, input logic [15:0] e);
    acc(1'b0, a, 16'h0000);
    chk($sformatf("reg %h", a), e, reg_rdata);
  endtask : rd
  // Far side moves n entries; received bytes must be acknowledged
  task automatic far(input logic rx, input int n);
    int c;
    c = 0;
    send_rx <= rx;
    take_tx <= ~rx;
    while (c < n) begin
      @(negedge ref_clk);
      if (rx_push_m | tx_pop_m) c++;
      if (rx_push_m) chk("rx_byte_ack", 16'h0001, 16'(rx_byte_ack));
      @(posedge ref_clk);
    end
    send_rx <= 1'b0;
    take_tx <= 1'b0;
  endtask : far
  // Processor pushes or pops for n cycles
  task automatic hold(input logic tx, input int n);
    tx_push_b <= tx;
    rx_pop_b <= ~tx;
    repeat (n) @(posedge ref_clk);
    tx_push_b <= 1'b0;
    rx_pop_b <= 1'b0;
  endtask : hold
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  // Watchdog well beyond the expected run
  initial begin
    repeat (4000) @(posedge ref_clk);
    miscompares++;
    wrap_up();
  end
  // Test sequence
  initial begin
    rst = 1'b1;
    reg_req = '0;
    {enable_bit, abort_event, abort_clear_read, tx_push_b, rx_pop_b, send_rx, take_tx, slow, busy} = '0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    for (int i = 0; i < 5; i++) rd(ad[i], 16'h0000);
    rd(32'h5000_1300, 16'h0000);
    acc(1'b1, ad[0], 16'hFFFF);
    rd(ad[0], 16'h0000);
    $display("test reset_values done");
    for (int r = 1; r < 3; r++) begin
      for (int i = 0; i < 4; i++) begin
        acc(1'b1, ad[r], wv[i]);
        rd(ad[r], ev[i]);
      end
    end
    $display("test thresholds done");
    enable_bit <= 1'b1;
    acc(1'b1, ad[1], 16'h0003);
    acc(1'b1, ad[2], 16'h0002);
    far(1'b1, 3);
    rd(ad[0], 16'h0010);
    far(1'b1, 1);
    rd(ad[0], 16'h0014);
    hold(1'b0, 1);
    rd(ad[0], 16'h0010);
    $display("test rx_level done");
    far(1'b1, 30);
    rd(ad[0], 16'h0016);
    chk("rx_level", 16'h0020, 16'(rx_level));
    hold(1'b1, 3);
    rd(ad[0], 16'h0006);
    hold(1'b1, 30);
    rd(ad[0], 16'h000E);
    chk("tx_level", 16'h0020, 16'(tx_level));
    slow <= 1'b1;
    far(1'b0, 30);
    slow <= 1'b0;
    rd(ad[0], 16'h001E);
    $display("test overruns done");
    hold(1'b0, 33);
    rd(ad[0], 16'h001B);
    rd(ad[4], 16'h0000);
    rd(ad[0], 16'h001A);
    far(1'b1, 4);
    rd(ad[3], 16'h0000);
    rd(ad[0], 16'h0014);
    $display("test clearing done");
    abort_event <= 1'b1;
    @(posedge ref_clk);
    abort_event <= 1'b0;
    hold(1'b1, 2);
    chk("tx_flushed", 16'h0001, 16'(tx_flushed));
    rd(ad[0], 16'h0014);
    abort_clear_read <= 1'b1;
    @(posedge ref_clk);
    abort_clear_read <= 1'b0;
    rd(ad[0], 16'h0014);
    abort_event <= 1'b1;
    @(posedge ref_clk);
    abort_event <= 1'b0;
    rd(ad[3], 16'h0000);
    chk("tx_flushed", 16'h0000, 16'(tx_flushed));
    $display("test abort done");
    hold(1'b0, 5);
    far(1'b1, 4);
    rd(ad[0], 16'h0015);
    busy <= 1'b1;
    enable_bit <= 1'b0;
    @(posedge ref_clk);
    rd(ad[0], 16'h0011);
    chk("internal_enable", 16'h0001, 16'(internal_enable));
    busy <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rd(ad[0], 16'h0000);
    chk("internal_enable", 16'h0000, 16'(internal_enable));
    $display("test disable done");
    chk("tx_push_taken", 16'h0020, 16'(push_cnt));
    chk("rx_byte_stored", 16'h0029, 16'(store_cnt));
    chk("rx_pop_valid", 16'h0025, 16'(pop_cnt));
    chk("clear_all_pulse", 16'h0003, 16'(clr_cnt));
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
